/* hdl/ucfg_map.svh */
// Constants for the configuration loader and suspend control.
// Assumes inclusion by bare name from files under hdl/.
`ifndef UCFG_MAP_SVH
`define UCFG_MAP_SVH
`define UCFG_NV_WORDS 8
`define UCFG_ADDR_W 3
`define UCFG_ADDR_LAST 3'h7
`define UCFG_ADDR_OPT 3'h0
`define UCFG_ADDR_PWR 3'h1
`define UCFG_ADDR_VER_LO 3'h2
`define UCFG_ADDR_VER_HI 3'h3
`define UCFG_ADDR_VID_LO 3'h4
`define UCFG_ADDR_VID_HI 3'h5
`define UCFG_ADDR_PID_LO 3'h6
`define UCFG_ADDR_PID_HI 3'h7
`define UCFG_BIT_SERIAL 0
`define UCFG_BIT_PULLDN 1
`define UCFG_BIT_SELFPWR 2
`define UCFG_BIT_WAKE 3
`define UCFG_BIT_HICUR 4
`define UCFG_BIT_DRVLOAD 5
`define UCFG_BIT_EXTOSC 6
`define UCFG_OPT_DEFAULT 8'h29
`define UCFG_PWR_DEFAULT 8'h2d
`define UCFG_VER_DEFAULT 16'h0200
`define UCFG_WAKE_MS 20
`define UCFG_CLK_KHZ 25000
`endif

/* hdl/ucfg_pkg.sv */
// Types shared by the configuration loader modules.
// Assumes ucfg_map.svh is available on the include path.
package ucfg_pkg;
	typedef enum logic [1:0]
	{
		UCFG_IDLE = 2'b00,
		UCFG_READ = 2'b01,
		UCFG_DONE = 2'b10
	} ucfg_state_t;
	typedef struct packed
	{
		logic extOsc;
		logic drvLoad;
		logic hiCurrent;
		logic remoteWake;
		logic selfPowered;
		logic suspendPullDown;
		logic serialEn;
	} ucfg_opts_t;
endpackage : ucfg_pkg

/* hdl/ucfg_nv_if.sv */
// Interface between the loader and its non-volatile store.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none
`include "ucfg_map.svh"
interface ucfg_nv_if;
	logic rdEn;
	logic [`UCFG_ADDR_W-1:0] addr;
	logic [7:0] data;
	modport loader (output rdEn, output addr, input data);
	modport store (input rdEn, input addr, output data);
endinterface : ucfg_nv_if
`default_nettype wire

/* hdl/ucfg_nv_store.sv */
// Non-volatile configuration store holding factory defaults until written.
// Assumes writes come from the programming path on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "ucfg_map.svh"
module ucfg_nv_store
	import ucfg_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic wrEn,
	input wire logic [`UCFG_ADDR_W-1:0] wrAddr,
	input wire logic [7:0] wrData,
	ucfg_nv_if.store nv
);
	logic [7:0] mem_q [`UCFG_NV_WORDS];
	function automatic logic [7:0] factoryWord(input logic [`UCFG_ADDR_W-1:0] a);
		logic [15:0] ver;
		ver = `UCFG_VER_DEFAULT;
		unique case (a)
			`UCFG_ADDR_OPT: factoryWord = `UCFG_OPT_DEFAULT;
			`UCFG_ADDR_PWR: factoryWord = `UCFG_PWR_DEFAULT;
			`UCFG_ADDR_VER_LO: factoryWord = ver[7:0];
			`UCFG_ADDR_VER_HI: factoryWord = ver[15:8];
			default: factoryWord = 8'h00;
		endcase
	endfunction : factoryWord
	generate
		for (genvar i = 0; i < `UCFG_NV_WORDS; i++)
		begin : gWord
			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
					mem_q[i] <= factoryWord(`UCFG_ADDR_W'(i));
				else if (clkEn && wrEn && wrAddr == `UCFG_ADDR_W'(i))
					mem_q[i] <= wrData;
			end
		end
	endgenerate
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			nv.data <= 8'h00;
		else if (clkEn && nv.rdEn)
			nv.data <= mem_q[nv.addr];
	end
endmodule : ucfg_nv_store
`default_nettype wire

/* hdl/ucfg_loader.sv */
// Configuration loader and suspend control of a USB-to-FIFO bridge.
// Assumes one clock; USB reset, suspend and the flag pin come from other domains.
// Summary of operation
// - After power-on or USB reset, reload descriptors and options from the store.
// - With wakeup enabled and link suspended, the receive flag pin becomes input.
// - Pulling that pin low in suspend signals wakeup; host resumes about 20 ms later.
// - Run on the internal oscillator unless the external option is stored.
// - Internal oscillator disabled with no external clock means no operation.
// - Factory defaults: serial on, pull-down off, 90mA, bus powered, wake on, drive-load on.
// - USB version field reads 0200, a full speed USB 2.0 device.
`timescale 1ns/1ns
`default_nettype none
`include "ucfg_map.svh"
module ucfg_loader
	import ucfg_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic usbReset,
	input wire logic usbSuspend,
	input wire logic nvWrEn,
	input wire logic [`UCFG_ADDR_W-1:0] nvWrAddr,
	input wire logic [7:0] nvWrData,
	input wire logic rxDataAvailIn,
	input wire logic rxDataAvail,
	input wire logic [7:0] fifoDataOut,
	input wire logic [7:0] fifoDataOe,
	input wire logic txSpaceAvail,
	output logic rx_data_avail_n_o,
	output logic rx_data_avail_n_oe,
	output logic tx_space_avail_n_o,
	output logic [7:0] fifoData_o,
	output logic [7:0] fifoData_oe,
	output logic power_enable_n,
	output logic configValid,
	output logic enumAllowed,
	output logic remoteWakeReq,
	output logic useExtOsc,
	output logic hiCurrent,
	output logic selfPowered,
	output logic serialEn,
	output logic drvLoad,
	output logic [7:0] maxPower,
	output logic [15:0] usbVersion,
	output logic [15:0] vendorId,
	output logic [15:0] productId
);
	localparam int WakeCycles = `UCFG_WAKE_MS * `UCFG_CLK_KHZ;
	ucfg_nv_if nv ();
	ucfg_nv_store uStore
	(
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.wrEn(nvWrEn),
		.wrAddr(nvWrAddr),
		.wrData(nvWrData),
		.nv(nv)
	);
	logic usbRst1_q, usbRst2_q, susp1_q, susp2_q, pin1_q, pin2_q;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			usbRst1_q <= 1'b0;
			usbRst2_q <= 1'b0;
			susp1_q <= 1'b0;
			susp2_q <= 1'b0;
			pin1_q <= 1'b1;
			pin2_q <= 1'b1;
		end
		else if (clkEn)
		begin
			usbRst1_q <= usbReset;
			usbRst2_q <= usbRst1_q;
			susp1_q <= usbSuspend;
			susp2_q <= susp1_q;
			pin1_q <= rxDataAvailIn;
			pin2_q <= pin1_q;
		end
	end
	ucfg_state_t state_q;
	logic [`UCFG_ADDR_W-1:0] addr_q;
	logic pending_q;
	logic lastRead;
	assign lastRead = (state_q == UCFG_READ) && (addr_q == `UCFG_ADDR_LAST);
	assign nv.rdEn = (state_q == UCFG_READ);
	assign nv.addr = addr_q;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= UCFG_IDLE;
			addr_q <= '0;
			pending_q <= 1'b0;
		end
		else if (clkEn)
		begin
			unique case (state_q)
				UCFG_IDLE:
				begin
					state_q <= UCFG_READ;
					addr_q <= '0;
				end
				UCFG_READ:
				begin
					pending_q <= nv.rdEn;
					if (usbRst2_q)
					begin
						addr_q <= '0;
						pending_q <= 1'b0;
					end
					else if (lastRead)
						state_q <= UCFG_DONE;
					else
						addr_q <= addr_q + 1'b1;
				end
				UCFG_DONE:
				begin
					pending_q <= 1'b0;
					if (usbRst2_q)
						state_q <= UCFG_IDLE;
				end
				default: state_q <= UCFG_IDLE;
			endcase
		end
	end
	logic [`UCFG_ADDR_W-1:0] capAddr_q;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			capAddr_q <= '0;
		else if (clkEn)
			capAddr_q <= addr_q;
	end
	logic [7:0] opt_q, pwr_q, verLo_q, verHi_q, vidLo_q, vidHi_q, pidLo_q, pidHi_q;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			opt_q <= 8'h00;
			pwr_q <= 8'h00;
			verLo_q <= 8'h00;
			verHi_q <= 8'h00;
			vidLo_q <= 8'h00;
			vidHi_q <= 8'h00;
			pidLo_q <= 8'h00;
			pidHi_q <= 8'h00;
		end
		else if (clkEn && pending_q)
		begin
			unique case (capAddr_q)
				`UCFG_ADDR_OPT: opt_q <= nv.data;
				`UCFG_ADDR_PWR: pwr_q <= nv.data;
				`UCFG_ADDR_VER_LO: verLo_q <= nv.data;
				`UCFG_ADDR_VER_HI: verHi_q <= nv.data;
				`UCFG_ADDR_VID_LO: vidLo_q <= nv.data;
				`UCFG_ADDR_VID_HI: vidHi_q <= nv.data;
				`UCFG_ADDR_PID_LO: pidLo_q <= nv.data;
				`UCFG_ADDR_PID_HI: pidHi_q <= nv.data;
			endcase
		end
	end
	logic valid_q;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			valid_q <= 1'b0;
		else if (clkEn)
			valid_q <= (state_q == UCFG_DONE) && !usbRst2_q && !pending_q;
	end
	ucfg_opts_t opts;
	always_comb
	begin
		opts = '0;
		if (valid_q)
		begin
			opts.serialEn = opt_q[`UCFG_BIT_SERIAL];
			opts.suspendPullDown = opt_q[`UCFG_BIT_PULLDN];
			opts.selfPowered = opt_q[`UCFG_BIT_SELFPWR];
			opts.remoteWake = opt_q[`UCFG_BIT_WAKE];
			opts.hiCurrent = opt_q[`UCFG_BIT_HICUR];
			opts.drvLoad = opt_q[`UCFG_BIT_DRVLOAD];
			opts.extOsc = opt_q[`UCFG_BIT_EXTOSC];
		end
	end
	logic suspended, wakeMode, pullMode;
	assign suspended = valid_q && susp2_q;
	assign wakeMode = suspended && opts.remoteWake;
	assign pullMode = suspended && opts.suspendPullDown;
	logic [24:0] wakeCnt_q;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			wakeCnt_q <= '0;
		else if (clkEn)
		begin
			if (!wakeMode)
				wakeCnt_q <= '0;
			else if (wakeCnt_q != '0)
				wakeCnt_q <= wakeCnt_q - 1'b1;
			else if (!pin2_q)
				wakeCnt_q <= WakeCycles[24:0];
		end
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_data_avail_n_o <= 1'b1;
			rx_data_avail_n_oe <= 1'b0;
			tx_space_avail_n_o <= 1'b1;
			fifoData_o <= 8'h00;
			fifoData_oe <= 8'h00;
			power_enable_n <= 1'b1;
			remoteWakeReq <= 1'b0;
		end
		else if (clkEn)
		begin
			power_enable_n <= !(valid_q && !susp2_q);
			remoteWakeReq <= wakeMode && !pin2_q && wakeCnt_q == '0;
			rx_data_avail_n_oe <= valid_q && !wakeMode;
			rx_data_avail_n_o <= pullMode ? 1'b0 : !rxDataAvail;
			tx_space_avail_n_o <= pullMode ? 1'b0 : !txSpaceAvail;
			fifoData_o <= pullMode ? 8'h00 : fifoDataOut;
			fifoData_oe <= pullMode ? 8'hff : (valid_q ? fifoDataOe : 8'h00);
		end
	end
	assign configValid = valid_q;
	assign enumAllowed = valid_q && !susp2_q;
	assign useExtOsc = opts.extOsc;
	assign hiCurrent = opts.hiCurrent;
	assign selfPowered = opts.selfPowered;
	assign serialEn = opts.serialEn;
	assign drvLoad = opts.drvLoad;
	assign maxPower = valid_q ? pwr_q : 8'h00;
	assign usbVersion = valid_q ? {verHi_q, verLo_q} : 16'h0000;
	assign vendorId = valid_q ? {vidHi_q, vidLo_q} : 16'h0000;
	assign productId = valid_q ? {pidHi_q, pidLo_q} : 16'h0000;
endmodule : ucfg_loader
`default_nettype wire

/* tb/ucfg_loader_properties.sv */
// Checker for the loader's top ports.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module ucfg_loader_properties
	import ucfg_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic usbReset,
	input wire logic rxDataAvailIn,
	input wire logic rx_data_avail_n_oe,
	input wire logic power_enable_n,
	input wire logic configValid,
	input wire logic remoteWakeReq,
	input wire logic [7:0] maxPower,
	input wire logic [15:0] usbVersion
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	sequence sPulse;
		remoteWakeReq ##1 !remoteWakeReq;
	endsequence
	a_opts_zero_loading: assert property (!configValid |-> maxPower == 8'h00)
		else $error("Options seen while loading.");
	a_power_off_unloaded: assert property (!configValid [*2] |-> power_enable_n)
		else $error("Power enabled while loading.");
	a_version_full_speed: assert property (configValid |-> usbVersion == 16'h0200)
		else $error("Wrong version field.");
	a_wake_pin_input: assert property (remoteWakeReq |-> !rx_data_avail_n_oe)
		else $error("Wake while flag pin driven.");
	a_wake_single_pulse: assert property (remoteWakeReq |-> sPulse)
		else $error("Wake pulse too long.");
	a_wake_from_strobe: assert property (remoteWakeReq |-> !$past(rxDataAvailIn, 3))
		else $error("Wake without strobe.");
	a_reset_reloads: assert property ($rose(usbReset) |-> ##[1:4] !configValid)
		else $error("No reload on link reset.");
	a_load_bounded: assert property ($fell(usbReset) |-> ##[1:20] configValid)
		else $error("Load too slow.");
endmodule : ucfg_loader_properties
bind ucfg_loader ucfg_loader_properties ucfg_loader_properties_inst (.clk, .rst_b, .usbReset,
	.rxDataAvailIn, .rx_data_avail_n_oe, .power_enable_n, .configValid, .remoteWakeReq,
	.maxPower, .usbVersion);
`default_nettype wire

/* tb/ucfg_mcu_model.sv */
// Controller side of the receive flag pin.
// Assumes a pull-up on the pin and a one-cycle wakeGo from the bench.
`timescale 1ns/1ns
`default_nettype none
module ucfg_mcu_model
(
	input wire logic clk,
	input wire logic wakeGo,
	input wire logic pinO,
	input wire logic pinOe,
	output logic pinLevel
);
	logic [2:0] lowCnt_q = 3'h0;
	// Strobes the pin low for four cycles, only once the device has released it.
	always @(posedge clk)
		lowCnt_q <= #2 (wakeGo && !pinOe) ? 3'h4 : lowCnt_q - {2'h0, lowCnt_q != 3'h0};
	// A released pin is pulled high.
	assign pinLevel = pinOe ? pinO : (lowCnt_q == 3'h0);
endmodule : ucfg_mcu_model
`default_nettype wire

/* tb/tb_ucfg_loader.sv */
// Bench for the configuration loader and suspend control.
// Assumes the checker is bound and the controller model drives the flag pin.
`timescale 1ns/1ns
`default_nettype none
module tb_ucfg_loader
	import ucfg_pkg::*;
;
	logic clk = 1'b0, rst_b = 1'b0, clkEn = 1'b1, usbReset = 1'b0, usbSuspend = 1'b0;
	logic nvWrEn = 1'b0, rxDataAvail = 1'b0, txSpaceAvail = 1'b1, wakeGo = 1'b0;
	logic [2:0] nvWrAddr = 3'h0;
	logic [7:0] nvWrData = 8'h00, fifoDataOut = 8'h5a, fifoDataOe = 8'h0f;
	logic rx_data_avail_n_o, rx_data_avail_n_oe, tx_space_avail_n_o, power_enable_n;
	logic configValid, enumAllowed, remoteWakeReq, useExtOsc, hiCurrent, selfPowered;
	logic serialEn, drvLoad, rxDataAvailIn;
	logic [7:0] fifoData_o, fifoData_oe, maxPower;
	logic [15:0] usbVersion, vendorId, productId;
	int errorCnt = 0, samplesChecked = 0, cyc = 0;
	ucfg_loader ucfg_loader_inst
	(
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.usbReset(usbReset),
		.usbSuspend(usbSuspend),
		.nvWrEn(nvWrEn),
		.nvWrAddr(nvWrAddr),
		.nvWrData(nvWrData),
		.rxDataAvailIn(rxDataAvailIn),
		.rxDataAvail(rxDataAvail),
		.fifoDataOut(fifoDataOut),
		.fifoDataOe(fifoDataOe),
		.txSpaceAvail(txSpaceAvail),
		.rx_data_avail_n_o(rx_data_avail_n_o),
		.rx_data_avail_n_oe(rx_data_avail_n_oe),
		.tx_space_avail_n_o(tx_space_avail_n_o),
		.fifoData_o(fifoData_o),
		.fifoData_oe(fifoData_oe),
		.power_enable_n(power_enable_n),
		.configValid(configValid),
		.enumAllowed(enumAllowed),
		.remoteWakeReq(remoteWakeReq),
		.useExtOsc(useExtOsc),
		.hiCurrent(hiCurrent),
		.selfPowered(selfPowered),
		.serialEn(serialEn),
		.drvLoad(drvLoad),
		.maxPower(maxPower),
		.usbVersion(usbVersion),
		.vendorId(vendorId),
		.productId(productId)
	);
	ucfg_mcu_model ucfg_mcu_model_inst (.clk, .wakeGo, .pinO(rx_data_avail_n_o),
		.pinOe(rx_data_avail_n_oe), .pinLevel(rxDataAvailIn));
	always #20 clk = ~clk;
	task step;
		@(posedge clk);
		#2;
	endtask : step
	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		samplesChecked++;
		if (s !== e)
		begin
			$display("unexpected %s: expected %h, seen %h", n, e, s);
			errorCnt++;
		end
	endtask : chk
	task final_report;
		$display("Checks %0d, mismatches %0d", samplesChecked, errorCnt);
		if (errorCnt == 0 && samplesChecked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	task wait_valid;
		for (int i = 0; i < 40 && configValid !== 1'b1; i++)
			step();
		chk("configValid", 1, configValid);
	endtask : wait_valid
	task wr_store(input logic [2:0] a, input logic [7:0] d);
		nvWrEn = 1'b1;
		nvWrAddr = a;
		nvWrData = d;
		step();
		nvWrEn = 1'b0;
		step();
	endtask : wr_store
	task t_defaults;
		wait_valid();
		chk("serialEn", 1, serialEn);
		chk("selfPowered", 0, selfPowered);
		chk("hiCurrent", 0, hiCurrent);
		chk("drvLoad", 1, drvLoad);
		chk("maxPower", 8'h2d, maxPower);
		chk("useExtOsc", 0, useExtOsc);
		chk("usbVersion", 16'h0200, usbVersion);
		chk("vendorId", 16'h0000, vendorId);
		chk("productId", 16'h0000, productId);
		step();
		chk("power_enable_n", 0, power_enable_n);
		chk("enumAllowed", 1, enumAllowed);
		chk("rx_data_avail_n_oe", 1, rx_data_avail_n_oe);
		chk("rx_data_avail_n_o", 1, rx_data_avail_n_o);
		chk("tx_space_avail_n_o", 0, tx_space_avail_n_o);
		chk("fifoData_o", 16'h005a, fifoData_o);
		chk("fifoData_oe", 16'h000f, fifoData_oe);
		clkEn = 1'b0;
		usbSuspend = 1'b1;
		repeat (6) step();
		chk("enumAllowed frozen", 1, enumAllowed);
		chk("power_enable_n frozen", 0, power_enable_n);
		clkEn = 1'b1;
		usbSuspend = 1'b0;
		repeat (3) step();
		$display("Defaults test done.");
	endtask : t_defaults
	task t_suspend(input logic pd);
		int n;
		n = 0;
		usbSuspend = 1'b1;
		txSpaceAvail = 1'b0;
		repeat (6) step();
		chk("rx_data_avail_n_oe", 0, rx_data_avail_n_oe);
		chk("power_enable_n", 1, power_enable_n);
		chk("enumAllowed", 0, enumAllowed);
		chk("fifoData_oe", pd ? 8'hff : 8'h0f, fifoData_oe);
		chk("tx_space_avail_n_o", pd ? 1'b0 : 1'b1, tx_space_avail_n_o);
		if (pd)
			chk("fifoData_o", 0, fifoData_o);
		wakeGo = 1'b1;
		step();
		wakeGo = 1'b0;
		repeat (12)
		begin
			step();
			n += (remoteWakeReq === 1'b1);
		end
		chk("wake pulses", 1, n);
		usbSuspend = 1'b0;
		txSpaceAvail = 1'b1;
		repeat (6) step();
		chk("enumAllowed", 1, enumAllowed);
		$display("Suspend test done.");
	endtask : t_suspend
	task t_reload;
		wr_store(3'h0, 8'h6b);
		wr_store(3'h1, 8'h32);
		chk("useExtOsc", 0, useExtOsc);
		usbReset = 1'b1;
		repeat (4) step();
		chk("configValid", 0, configValid);
		chk("maxPower", 0, maxPower);
		usbReset = 1'b0;
		wait_valid();
		chk("useExtOsc", 1, useExtOsc);
		chk("maxPower", 8'h32, maxPower);
		$display("Reload test done.");
	endtask : t_reload
	initial
	begin
		repeat (10) @(posedge clk);
		#2 rst_b = 1'b1;
		t_defaults();
		t_suspend(1'b0);
		t_reload();
		t_suspend(1'b1);
		final_report();
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			errorCnt++;
			final_report();
		end
	end
endmodule : tb_ucfg_loader
`default_nettype wire
